/* insn_classifier_pkg.sv */
// package: opcode map, move field layout, register map and decode types
// Behaviour
// - exactly 55 instructions in eight groups
// - arithmetic group holds fourteen instructions
// - shift group holds eight instructions
// - bit manipulation group holds fourteen instructions
// - system control group holds eight instructions
// - conditional branch carries a condition field
// - push equals word move, pre-decrement stack
// - pop equals word move, post-increment stack
// - push and pop share move encodings
// - move: byte/word, reg, memory, immediate
// - word moves accept the seven listed modes
// - short absolute decoded for byte moves only
// - push and pop move full 16-bit registers
// - flags register holds negative, zero, overflow, carry
// - post-increment adds one or two after access
// - pre-decrement subtracts one or two, keeps it
// - short absolute upper byte is all ones
package insn_classifier_pkg;
   localparam int INSN_COUNT = 55;
   localparam int ARITH_COUNT = 14;
   localparam int LOGIC_COUNT = 4;
   localparam int SHIFT_COUNT = 8;
   localparam int BIT_COUNT = 14;
   localparam int BRANCH_COUNT = 5;
   localparam int SYSTEM_COUNT = 8;
   // opcode ids in insn[15:10]; group ranges are contiguous
   localparam logic [5:0] OP_ADD = 6'h00;
   localparam logic [5:0] OP_SUB = 6'h01;
   localparam logic [5:0] OP_ADDS = 6'h06;
   localparam logic [5:0] OP_SUBS = 6'h07;
   localparam logic [5:0] OP_CMP = 6'h0c;
   localparam logic [5:0] OP_LOGIC_BASE = 6'h0e;
   localparam logic [5:0] OP_SHIFT_BASE = 6'h12;
   localparam logic [5:0] OP_BIT_BASE = 6'h1a;
   localparam logic [5:0] OP_BRANCH_BASE = 6'h28;
   localparam logic [5:0] OP_BCC = 6'h28;
   localparam logic [5:0] OP_SYSTEM_BASE = 6'h2d;
   localparam logic [5:0] OP_ANDC = 6'h31;
   localparam logic [5:0] OP_ORC = 6'h32;
   localparam logic [5:0] OP_XORC = 6'h33;
   localparam logic [5:0] block_copy_op = 6'h35;
   localparam logic [5:0] OP_LIMIT = 6'h36;
   localparam logic [5:0] move_op = 6'h38;
   // move layout: [15:13] class, [12] word, [11] store, [10:8] mode, [7:5] ea reg, [4:2] data reg
   localparam logic [2:0] MOVE_CLASS = 3'h7;
   localparam int SIZE_BIT = 12;
   localparam int DIR_BIT = 11;
   localparam int MODE_LSB = 8;
   localparam int EAREG_LSB = 5;
   localparam int COND_LSB = 6;
   localparam int OP_LSB = 10;
   localparam logic [2:0] stack_general_register = 3'h7;
   localparam logic [7:0] SHORT_ABS_PAGE = 8'hff;
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   // apb byte offsets
   localparam logic [11:0] ADDR_INSN = 12'h000;
   localparam logic [11:0] ADDR_OPERAND = 12'h004;
   localparam logic [11:0] ADDR_FLAGS = 12'h008;
   localparam logic [11:0] ADDR_RESULT = 12'h00c;
   localparam logic [11:0] ADDR_ADDRESS = 12'h010;
   localparam logic [15:0] INSN_RESET = 16'h0000;
   localparam logic [15:0] OPERAND_RESET = 16'h0000;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   // flag positions: n, z, v, c from msb down
   localparam int FLAG_N = 3;
   localparam int FLAG_C = 0;

   typedef enum logic [3:0] {
      GRP_NONE = 4'h0, GRP_TRANSFER = 4'h1, GRP_ARITH = 4'h2, GRP_LOGIC = 4'h3, GRP_SHIFT = 4'h4,
      GRP_BIT = 4'h5, GRP_BRANCH = 4'h6, GRP_SYSTEM = 4'h7, GRP_BLOCK = 4'h8
   } group_t;

   typedef enum logic [2:0] {
      MODE_REG_DIRECT = 3'h0, MODE_REG_INDIRECT = 3'h1, MODE_DISPLACEMENT = 3'h2,
      MODE_SHORT_ABS = 3'h3, MODE_LONG_ABS = 3'h4, MODE_IMMEDIATE = 3'h5,
      MODE_PREDEC = 3'h6, MODE_POSTINC = 3'h7
   } mode_t;
endpackage

/* ea_step.sv */
// effective address and register update for the move modes
`timescale 1ns/1ps
module ea_step
   import insn_classifier_pkg::*;
(
   input wire mode_t mode_i,
   input wire logic word_i,
   input wire logic [15:0] base_i,
   output logic [15:0] addr_o,
   output logic [15:0] upd_o
);
   logic [15:0] step; // one for byte, two for word

   // address and written-back register value per mode
   always_comb begin
      step = word_i ? STEP_WORD : STEP_BYTE;
      addr_o = base_i;
      upd_o = base_i;
      case (mode_i)
         MODE_PREDEC: begin
            // register keeps the decremented value
            addr_o = base_i - step;
            upd_o = base_i - step;
         end
         MODE_POSTINC: begin
            // access uses the old value, step applies afterwards
            upd_o = base_i + step;
         end
         MODE_SHORT_ABS: begin
            // only the low byte is given; it lands in the top page
            addr_o = {SHORT_ABS_PAGE, base_i[7:0]};
         end
         default: begin
            addr_o = base_i;
         end
      endcase
   end
endmodule

/* insn_classifier.sv */
// instruction classifier and move decoder behind an apb register port
`timescale 1ns/1ps
module insn_classifier
   import insn_classifier_pkg::*;
#(
   parameter int INSN_TOTAL = INSN_COUNT
)
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic decode_valid_o,
   output logic undefined_o,
   output group_t group_o,
   output logic word_size_o,
   output mode_t mode_o,
   output logic push_o,
   output logic pop_o,
   output logic [3:0] cond_o,
   output logic [3:0] flags_o
);
   // the opcode map only serves the documented total
   localparam int MAP_TOTAL = 1 + ARITH_COUNT + LOGIC_COUNT + SHIFT_COUNT + BIT_COUNT
      + BRANCH_COUNT + SYSTEM_COUNT + 1;
   if (INSN_TOTAL != MAP_TOTAL) begin : g_count_check
      $error("instruction total does not match the opcode map");
   end

   // all state of the block
   typedef struct packed {
      logic [15:0] insn; // last instruction word written
      logic [15:0] operand; // address register contents or absolute value
      logic [3:0] flags; // condition_flags_register
      logic valid; // a decode has been done
      logic undef; // last code matched nothing or was an illegal move
      group_t group; // functional group
      logic word; // word operand size
      mode_t mode; // addressing mode of a move
      logic [5:0] opid; // opcode id, move_op for moves
      logic push; // move that is a stack push
      logic pop; // move that is a stack pop
      logic [3:0] cond; // branch condition field
      logic [15:0] addr; // operand address
      logic [15:0] upd; // address register after the access
      logic [31:0] prdata; // read data, loaded in setup
      logic pslverr; // unmapped address seen in setup
      logic pready; // zero wait states once out of reset
   } state_t;

   state_t s_reg;
   state_t s_next;

   // decode scratch
   logic [15:0] ins; // instruction being decoded
   logic [5:0] op; // opcode id field
   logic is_move; // class bits select a move
   logic store; // move writes memory
   logic wsz; // move size bit
   mode_t m; // move mode field
   logic [2:0] ea_r; // move address register
   logic bad_move; // illegal move form: mode with size or direction, byte stack access, or reserved bits set
   logic setup; // apb setup cycle
   logic wr; // apb write taking effect
   logic [15:0] ea_addr; // from the address stepper
   logic [15:0] ea_upd; // from the address stepper
   logic [15:0] operand_new; // operand as it stands after this cycle's write

   // address stepper works on the values being decoded this cycle
   ea_step u_ea_step (
      .mode_i(m),
      .word_i(wsz),
      .base_i(operand_new),
      .addr_o(ea_addr),
      .upd_o(ea_upd)
   );

   // field extraction from the word that will be stored this cycle
   always_comb begin
      ins = (wr && paddr_i == ADDR_INSN) ? pwdata_i[15:0] : s_reg.insn;
      // kept apart from the state copy so the stepper does not loop through it
      operand_new = (wr && paddr_i == ADDR_OPERAND) ? pwdata_i[15:0] : s_reg.operand;
      op = ins[15:OP_LSB];
      is_move = ins[15:13] == MOVE_CLASS;
      store = ins[DIR_BIT];
      wsz = ins[SIZE_BIT];
      m = mode_t'(ins[MODE_LSB +: 3]);
      ea_r = ins[EAREG_LSB +: 3];
   end

   // apb phase decode
   always_comb begin
      setup = psel_i && !penable_i;
      wr = psel_i && penable_i && pwrite_i && s_reg.pready;
   end

   // move legality
   always_comb begin
      bad_move = 1'b0;
      if (m == MODE_SHORT_ABS && wsz) begin
         bad_move = 1'b1;
      end else if (m == MODE_IMMEDIATE && store) begin
         bad_move = 1'b1;
      end else if (m == MODE_PREDEC && !store) begin
         bad_move = 1'b1; // pre-decrement only stores
      end else if (m == MODE_POSTINC && store) begin
         bad_move = 1'b1; // post-increment only loads
      end else if (!wsz && ea_r == stack_general_register && (m == MODE_PREDEC || m == MODE_POSTINC)) begin
         // byte on the stack would misalign it; refuse rather than guess
         bad_move = 1'b1;
      end else if (ins[1:0] != 2'b00) begin
         bad_move = 1'b1; // reserved bits must be clear
      end
   end

   // next state: register writes, decode, read capture
   always_comb begin
      s_next = s_reg;
      s_next.pready = 1'b1;
      // register writes take effect only in the access phase
      if (wr) begin
         if (paddr_i == ADDR_INSN) begin
            s_next.insn = pwdata_i[15:0];
         end else if (paddr_i == ADDR_OPERAND) begin
            s_next.operand = pwdata_i[15:0];
         end else if (paddr_i == ADDR_FLAGS) begin
            s_next.flags = pwdata_i[FLAG_N:FLAG_C];
         end
      end
      // a new word or operand both redo the decode at once
      if (wr && (paddr_i == ADDR_INSN || paddr_i == ADDR_OPERAND)) begin
         s_next.valid = 1'b1;
         s_next.undef = 1'b0;
         s_next.word = 1'b0;
         s_next.mode = MODE_REG_DIRECT;
         s_next.push = 1'b0;
         s_next.pop = 1'b0;
         s_next.cond = 4'h0;
         s_next.addr = ea_addr;
         s_next.upd = ea_upd;
         s_next.opid = op;
         if (is_move) begin
            // one instruction covers every move form
            s_next.opid = move_op;
            s_next.group = GRP_TRANSFER;
            s_next.word = wsz;
            s_next.mode = m;
            // stack forms need no codes of their own
            s_next.push = wsz && store && m == MODE_PREDEC && ea_r == stack_general_register;
            s_next.pop = wsz && !store && m == MODE_POSTINC && ea_r == stack_general_register;
            if (bad_move) begin
               s_next.undef = 1'b1;
               s_next.group = GRP_NONE;
               s_next.push = 1'b0;
               s_next.pop = 1'b0;
            end
         end else if (op < OP_LOGIC_BASE) begin
            s_next.group = GRP_ARITH;
            // these arithmetic forms carry word operands
            s_next.word = (op == OP_ADDS || op == OP_SUBS)
               || (ins[9] && (op == OP_ADD || op == OP_SUB || op == OP_CMP));
         end else if (op < OP_SHIFT_BASE) begin
            s_next.group = GRP_LOGIC;
         end else if (op < OP_BIT_BASE) begin
            s_next.group = GRP_SHIFT;
         end else if (op < OP_BRANCH_BASE) begin
            s_next.group = GRP_BIT;
         end else if (op < OP_SYSTEM_BASE) begin
            s_next.group = GRP_BRANCH;
            // all conditions share one code, the field picks the test
            if (op == OP_BCC) begin
               s_next.cond = ins[COND_LSB +: 4];
            end
         end else if (op < block_copy_op) begin
            s_next.group = GRP_SYSTEM;
            // immediate flag logic acts on the low nibble, only on a new word:
            // an operand rewrite redecodes but must not repeat the operation
            if (paddr_i == ADDR_INSN && op == OP_ANDC) begin
               s_next.flags = s_next.flags & ins[3:0];
            end else if (paddr_i == ADDR_INSN && op == OP_ORC) begin
               s_next.flags = s_next.flags | ins[3:0];
            end else if (paddr_i == ADDR_INSN && op == OP_XORC) begin
               s_next.flags = s_next.flags ^ ins[3:0];
            end
         end else if (op < OP_LIMIT) begin
            s_next.group = GRP_BLOCK;
         end else begin
            // codes past the map never alias a real instruction
            s_next.group = GRP_NONE;
            s_next.undef = 1'b1;
         end
      end
      // read data is captured in setup so it is ready in the access phase
      if (setup) begin
         s_next.pslverr = 1'b0;
         if (paddr_i == ADDR_INSN) begin
            s_next.prdata = {16'h0000, s_reg.insn};
         end else if (paddr_i == ADDR_OPERAND) begin
            s_next.prdata = {16'h0000, s_reg.operand};
         end else if (paddr_i == ADDR_FLAGS) begin
            s_next.prdata = {28'h0000000, s_reg.flags};
         end else if (paddr_i == ADDR_RESULT) begin
            s_next.prdata = {10'h000, s_reg.cond, s_reg.pop, s_reg.push, s_reg.opid, s_reg.mode,
               s_reg.word, s_reg.group, s_reg.undef, s_reg.valid};
         end else if (paddr_i == ADDR_ADDRESS) begin
            s_next.prdata = {s_reg.upd, s_reg.addr};
         end else begin
            // unmapped: zero data and an error answer
            s_next.prdata = 32'h00000000;
            s_next.pslverr = 1'b1;
         end
      end
   end

   // single state register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg.insn <= INSN_RESET;
         s_reg.operand <= OPERAND_RESET;
         s_reg.flags <= FLAGS_RESET;
         s_reg.valid <= 1'b0;
         s_reg.undef <= 1'b0;
         s_reg.group <= GRP_NONE;
         s_reg.word <= 1'b0;
         s_reg.mode <= MODE_REG_DIRECT;
         s_reg.opid <= 6'h00;
         s_reg.push <= 1'b0;
         s_reg.pop <= 1'b0;
         s_reg.cond <= 4'h0;
         s_reg.addr <= 16'h0000;
         s_reg.upd <= 16'h0000;
         s_reg.prdata <= 32'h00000000;
         s_reg.pslverr <= 1'b0;
         s_reg.pready <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign prdata_o = s_reg.prdata;
   assign pready_o = s_reg.pready;
   assign pslverr_o = s_reg.pslverr;
   assign decode_valid_o = s_reg.valid;
   assign undefined_o = s_reg.undef;
   assign group_o = s_reg.group;
   assign word_size_o = s_reg.word;
   assign mode_o = s_reg.mode;
   assign push_o = s_reg.push;
   assign pop_o = s_reg.pop;
   assign cond_o = s_reg.cond;
   assign flags_o = s_reg.flags;

   // checks on the decode outputs
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_insn_write;
      psel_i && penable_i && pwrite_i && pready_o && paddr_i == ADDR_INSN;
   endsequence

   sequence s_decoded(logic [15:0] w);
      decode_valid_o && s_reg.insn == w;
   endsequence

   property p_decode_follows;
      logic [15:0] w;
      (s_insn_write, w = pwdata_i[15:0]) |=> s_decoded(w);
   endproperty
   a_decode_follows: assert property (p_decode_follows) else $error("decode did not follow write");

   property p_short_abs_byte_only;
      decode_valid_o && s_reg.insn[15:13] == MOVE_CLASS && s_reg.insn[MODE_LSB +: 3] == MODE_SHORT_ABS
         && s_reg.insn[SIZE_BIT] |-> undefined_o;
   endproperty
   a_short_abs_byte_only: assert property (p_short_abs_byte_only) else $error("word short absolute accepted");

   property p_push_shape;
      push_o |-> group_o == GRP_TRANSFER && word_size_o && mode_o == MODE_PREDEC && !pop_o;
   endproperty
   a_push_shape: assert property (p_push_shape) else $error("push not a word pre-decrement move");

   property p_pop_shape;
      pop_o |-> group_o == GRP_TRANSFER && word_size_o && mode_o == MODE_POSTINC && !undefined_o;
   endproperty
   a_pop_shape: assert property (p_pop_shape) else $error("pop not a word post-increment move");

   property p_stack_encoding;
      (push_o || pop_o) |-> s_reg.insn[EAREG_LSB +: 3] == stack_general_register
         && s_reg.opid == move_op;
   endproperty
   a_stack_encoding: assert property (p_stack_encoding) else $error("stack op off the move code");

   property p_postinc_step;
      decode_valid_o && !undefined_o && mode_o == MODE_POSTINC |->
         s_reg.upd == s_reg.operand + (word_size_o ? STEP_WORD : STEP_BYTE) && s_reg.addr == s_reg.operand;
   endproperty
   a_postinc_step: assert property (p_postinc_step) else $error("post-increment step wrong");

   property p_predec_step;
      decode_valid_o && !undefined_o && mode_o == MODE_PREDEC |->
         s_reg.addr == s_reg.operand - (word_size_o ? STEP_WORD : STEP_BYTE) && s_reg.upd == s_reg.addr;
   endproperty
   a_predec_step: assert property (p_predec_step) else $error("pre-decrement step wrong");

   property p_short_abs_page;
      decode_valid_o && mode_o == MODE_SHORT_ABS |-> s_reg.addr == {SHORT_ABS_PAGE, s_reg.operand[7:0]};
   endproperty
   a_short_abs_page: assert property (p_short_abs_page) else $error("short absolute page wrong");

   property p_undef_no_group;
      undefined_o |-> group_o == GRP_NONE && !push_o && !pop_o;
   endproperty
   a_undef_no_group: assert property (p_undef_no_group) else $error("undefined code got a group");

   property p_arith_range;
      decode_valid_o && group_o == GRP_ARITH |-> s_reg.opid < OP_LOGIC_BASE;
   endproperty
   a_arith_range: assert property (p_arith_range) else $error("arithmetic id out of range");

   property p_cond_field;
      decode_valid_o && group_o == GRP_BRANCH && s_reg.opid == OP_BCC |-> cond_o == s_reg.insn[9:6];
   endproperty
   a_cond_field: assert property (p_cond_field) else $error("condition field lost");

   property p_flags_write;
      logic [3:0] f;
      (psel_i && penable_i && pwrite_i && pready_o && paddr_i == ADDR_FLAGS, f = pwdata_i[3:0])
         |=> flags_o == f ##1 $stable(flags_o) || $past(psel_i);
   endproperty
   a_flags_write: assert property (p_flags_write) else $error("flags write lost");
endmodule

/* stack_program.sv */
// far-side program source: push and pop codes as software writes them
`timescale 1ns/1ps
module stack_program
   import insn_classifier_pkg::*;
(
   input wire logic [2:0] reg_i,
   input wire logic pop_i,
   output logic [15:0] code_o
);
   // no own codes for the stack: word moves only
   // pop loads with post-increment
   // push stores with pre-decrement
   assign code_o = pop_i ? {MOVE_CLASS, 2'b10, MODE_POSTINC, stack_general_register, reg_i, 2'b00}
                         : {MOVE_CLASS, 2'b11, MODE_PREDEC, stack_general_register, reg_i, 2'b00};
endmodule

/* insn_classifier_tb.sv */
// self-checking testbench for the instruction classifier
`timescale 1ns/1ps
module insn_classifier_tb;
   import insn_classifier_pkg::*;
   logic clk_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic decode_valid_o, undefined_o, word_size_o, push_o, pop_o, err, u;
   group_t group_o;
   mode_t mode_o;
   logic [3:0] cond_o, flags_o, fl, imm;
   logic [2:0] stk_reg;  // register handed to the stack program
   logic stk_pop;
   logic [15:0] stk_code, base, step;
   int miscompares = 0;
   int n_tests = 0;
   int seed = 52842;
   int cnt [16];  // opcodes seen per reported group

   insn_classifier #(.INSN_TOTAL(55)) DUT (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .decode_valid_o, .undefined_o, .group_o, .word_size_o,
      .mode_o, .push_o, .pop_o, .cond_o, .flags_o);
   stack_program prog (.reg_i(stk_reg), .pop_i(stk_pop), .code_o(stk_code));

   // 200 mhz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer plus an idle cycle, so no signal is set twice at one edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // decode one code in the model and compare with the design
   task automatic run(input logic [15:0] code, output logic und);
      logic [5:0] op;
      logic w, st, ea7, psh, pp;
      logic [3:0] c;
      group_t g;
      mode_t m;
      op = code[15:10];
      m = MODE_REG_DIRECT;
      psh = 1'b0;
      pp = 1'b0;
      w = (op <= OP_SUB || op == OP_CMP) ? code[9] : (op == OP_ADDS || op == OP_SUBS);
      c = (op == OP_BCC) ? code[9:6] : 4'h0;
      und = op >= OP_LIMIT;
      g = op < OP_LOGIC_BASE ? GRP_ARITH : op < OP_SHIFT_BASE ? GRP_LOGIC : op < OP_BIT_BASE ? GRP_SHIFT :
          op < OP_BRANCH_BASE ? GRP_BIT : op < OP_SYSTEM_BASE ? GRP_BRANCH : op < block_copy_op ? GRP_SYSTEM : GRP_BLOCK;
      if (code[15:13] == MOVE_CLASS) begin
         g = GRP_TRANSFER;
         w = code[12];
         st = code[11];
         m = mode_t'(code[10:8]);
         c = 4'h0;
         ea7 = code[7:5] == stack_general_register;
         und = (w && m == MODE_SHORT_ABS) || (st && m == MODE_IMMEDIATE) || (!st && m == MODE_PREDEC) ||
               (st && m == MODE_POSTINC) || (!w && ea7 && m >= MODE_PREDEC) || code[1:0] != 2'b00;
         psh = w && st && ea7 && m == MODE_PREDEC;
         pp = w && !st && ea7 && m == MODE_POSTINC;
      end
      apb(1'b1, ADDR_INSN, {16'h0000, code});
      apb(1'b0, ADDR_RESULT, 32'h0);
      check({undefined_o, decode_valid_o, rd[1:0]}, {und, 1'b1, und, 1'b1});
      if (!und) begin
         check({group_o, word_size_o, cond_o}, {g, w, c});
         check({rd[21:18], rd[5:2]}, {c, g});
         cnt[group_o]++;
      end
      if (!und && g == GRP_TRANSFER) begin
         check({mode_o, push_o, pop_o, rd[17:16]}, {m, psh, pp, pp, psh});
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // watchdog: the tests need about 1400 cycles
   initial begin
      repeat (40000) @(posedge clk_i);
      miscompares++;
      results();
   end

   initial begin
      reset_n_i = 1'b0;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      stk_reg = 3'h0;
      stk_pop = 1'b0;
      repeat (20) @(posedge clk_i);
      check({pready_o, decode_valid_o, group_o}, 32'h0);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
      $display("test reset done");
      // every opcode outside the move class, then every branch condition
      for (int op = 0; op < 56; op++) begin
         run({6'(op), 10'(rnd())}, u);
      end
      for (int cc = 0; cc < 16; cc++) begin
         run({OP_BCC, 4'(cc), 6'(rnd())}, u);
      end
      check(cnt[GRP_ARITH], 14 + 16 * 0);
      check(cnt[GRP_SHIFT], 8);
      check(cnt[GRP_BIT], 14);
      check(cnt[GRP_SYSTEM], 8);
      check(cnt[GRP_LOGIC] + cnt[GRP_BRANCH] - 16 + cnt[GRP_BLOCK], 10);
      $display("test groups done");
      // every size, direction and mode, on the stack register and others
      for (int i = 0; i < 64; i++) begin
         run({MOVE_CLASS, i[0], i[1], 3'(i >> 2), i[5] ? 3'h7 : 3'(rnd() % 7), 3'(rnd()), 2'b00}, u);
         step = i[0] ? STEP_WORD : STEP_BYTE;
         base = {15'(rnd()), 1'b0};
         apb(1'b1, ADDR_OPERAND, {16'h0, base});
         apb(1'b0, ADDR_ADDRESS, 32'h0);
         if (!u && i[4:2] == 3'h3) check(rd[15:0], {SHORT_ABS_PAGE, base[7:0]});
         if (!u && i[4:2] == 3'h6) check(rd, {base - step, base - step});
         if (!u && i[4:2] == 3'h7) check(rd, {base + step, base});
      end
      run({MOVE_CLASS, 11'h0a0, 2'b01}, u);
      check(u, 1'b1);
      $display("test moves done");
      // push and pop from the program source
      for (int i = 0; i < 16; i++) begin
         stk_reg <= 3'(i);
         stk_pop <= i[3];
         @(posedge clk_i);
         run(stk_code, u);
         check({u, word_size_o, push_o, pop_o}, {2'b01, !i[3], i[3]});
      end
      $display("test stack done");
      // flags register and the immediate flag operations
      for (int op = 49; op < 52; op++) begin
         fl = 4'(rnd());
         imm = 4'(rnd());
         apb(1'b1, ADDR_FLAGS, {28'(rnd()), fl});
         apb(1'b0, ADDR_FLAGS, 32'h0);
         check(rd, {28'h0, fl});
         check(flags_o, fl);
         run({6'(op), 6'h00, imm}, u);
         fl = op == 49 ? fl & imm : op == 50 ? fl | imm : fl ^ imm;
         check(flags_o, fl);
         apb(1'b1, ADDR_OPERAND, 32'(rnd()));
         check(flags_o, fl);
      end
      $display("test flags done");
      // unmapped offsets answer with an error and zero data
      apb(1'b0, 12'h014, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, 12'h7f0, 32'hffffffff);
      check(err, 1'b1);
      $display("test unmapped done");
      results();
   end
endmodule
